// ==== verilog/hw_reset_pkg.sv ====
package hw_reset_pkg;

    // machine cycle: six oscillator periods, index 0 is state 5
    localparam int          OSC_PER_MCYCLE = 6;
    localparam logic [2:0]  STATE_LAST     = 3'h5;
    localparam logic [2:0]  STATE_S5       = 3'h0;
    localparam logic [2:0]  STATE_RESET    = 3'h0;

    // defaults applied by the internal reset
    localparam logic [15:0] RESET_PC       = 16'h0000;
    localparam logic [7:0]  PORT_RESET     = 8'hff;
    localparam int          NUM_PORTS      = 5;

    // synchronised pin vector positions
    localparam int          PIN_RESET      = 0;
    localparam int          PIN_ALE        = 1;
    localparam int          PIN_FETCH      = 2;
    localparam int          NUM_PINS       = 3;

    // idle levels of the strobe pins when driven
    localparam logic        ALE_IDLE       = 1'b0;
    localparam logic        FETCH_IDLE     = 1'b1;

    typedef struct packed {
        logic [7:0] p4;
        logic [7:0] p3;
        logic [7:0] p2;
        logic [7:0] p1;
        logic [7:0] p0;
    } port_latch_t;

    typedef struct packed {
        logic       valid;
        logic [2:0] port;
        logic [7:0] data;
    } port_write_t;

    typedef struct packed {
        logic [7:0] p0PullLow;
        logic [7:0] p1Level;
        logic [7:0] p2Level;
        logic [7:0] p3Level;
        logic [7:0] p4Level;
    } port_drive_t;

endpackage : hw_reset_pkg

// ==== verilog/machine_cycle_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module machine_cycle_timer
(
    input  wire logic       clk,
    input  wire logic       rst,
    output var  logic [2:0] stateNum,
    output var  logic       tick
);

    logic [2:0] count_ff;
    logic       tick_ff;
    wire  logic atLast = (count_ff == hw_reset_pkg::STATE_LAST);
    wire  logic [2:0] nxt_count = atLast ? hw_reset_pkg::STATE_S5 : count_ff + 3'h1;

    // tick marks state 5: sample, strobe and release all share it
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            count_ff <= hw_reset_pkg::STATE_RESET;
            tick_ff  <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            tick_ff  <= atLast;
        end
    end

    assign stateNum = count_ff;
    assign tick     = tick_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tick_period: assert property (tick |=> !tick [*5] ##1 tick) // R16
        else $error("machine cycle tick not every six clocks");

endmodule : machine_cycle_timer

`default_nettype wire

// ==== verilog/external_hardware_reset.sv ====
// Behaviour
// R1: high reset pin asserts, synchronised first
// R2: source holds pin twelve oscillator periods
// R3: reset in second cycle, repeated while high
// R4: strobe pins become inputs during reset
// R5: outside logic leaves strobe pins undriven
// R6: power-up hold: oscillator start plus two
// R7: execution starts at address zero
// R8: reset loads ports 0-4 with ones
// R9: port 0 floats, ports 1-4 drive one
// R10: reset loads special registers with defaults
// R11: reset leaves internal memories untouched
// R12: watchdog and oscillator watchdog also reset
// R13: reset ends power-down mode
// R14: pin sampled once per cycle, state 5
// R15: release seen at sample, run next state 5
// R16: six-clock machine cycle, boundary-aligned changes
`timescale 1ns/1ps
`default_nettype none

module external_hardware_reset
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      resetPin,
    input  wire logic                      wdtResetReq,
    input  wire logic                      oscWdtResetReq,
    input  wire logic                      enterPowerDown,
    input  wire hw_reset_pkg::port_write_t portWrite,
    input  wire logic                      aleIn,
    input  wire logic                      programFetchStrobeIn,
    output var  logic                      aleOut,
    output var  logic                      aleOe,
    output var  logic                      programFetchStrobeOut,
    output var  logic                      programFetchStrobeOe,
    output var  logic                      sysReset,
    output var  logic                      sfrLoadDefaults,
    output var  logic                      fetchStart,
    output var  logic [15:0]               fetchAddr,
    output var  logic                      ramWriteBlock,
    output var  logic                      powerDown,
    output var  logic                      testModeHazard,
    output var  hw_reset_pkg::port_latch_t portLatch,
    output var  hw_reset_pkg::port_drive_t portDrive
);

    logic [hw_reset_pkg::NUM_PINS-1:0] pinMeta_ff;
    logic [hw_reset_pkg::NUM_PINS-1:0] pinSync_ff;
    logic                              tick;
    logic [2:0]                        stateNum;
    logic                              armed_ff;
    logic                              inReset_ff;
    logic                              oe_ff;
    logic                              releasePending_ff;
    logic                              strobe_ff;
    logic                              fetchStart_ff;
    logic [15:0]                       fetchAddr_ff;
    logic                              powerDown_ff;
    logic                              hazard_ff;
    hw_reset_pkg::port_latch_t         latch_ff;
    hw_reset_pkg::port_drive_t         drive_ff;

    wire hw_reset_pkg::port_latch_t nxt_latch;
    wire hw_reset_pkg::port_drive_t nxt_drive;

    // asynchronous pins pass two flops before anything reads them
    genvar gi;
    generate
        for (gi = 0; gi < hw_reset_pkg::NUM_PINS; gi++)
        begin : g_sync
            wire logic pinRaw = (gi == hw_reset_pkg::PIN_RESET) ? resetPin :
                                (gi == hw_reset_pkg::PIN_ALE)   ? aleIn : programFetchStrobeIn;
            always_ff @(posedge clk)
            begin
                pinMeta_ff[gi] <= pinRaw;
                pinSync_ff[gi] <= pinMeta_ff[gi];
            end
        end
    endgenerate

    machine_cycle_timer u_timer
    (
        .clk      (clk),
        .rst      (rst),
        .stateNum (stateNum),
        .tick     (tick)
    );

    // internal sources join the pin at the same sample point
    wire logic reqNow     = pinSync_ff[hw_reset_pkg::PIN_RESET] | wdtResetReq | oscWdtResetReq; // R1 R12
    wire logic sampleHigh = tick & reqNow;     // R14
    wire logic sampleLow  = tick & !reqNow;    // R14
    wire logic doStrobe   = sampleHigh & (armed_ff | inReset_ff); // R3
    wire logic doRelease  = sampleLow & inReset_ff & releasePending_ff; // R15
    // a lone sample cannot start a reset: outside reset, pulses of six clocks or fewer are rejected
    wire logic nxt_armed  = tick ? reqNow : armed_ff;
    wire logic nxt_inRst  = doStrobe | (inReset_ff & !doRelease);
    wire logic nxt_relPnd = tick ? (!reqNow & inReset_ff & !releasePending_ff) : releasePending_ff;
    wire logic wrHit      = portWrite.valid & !inReset_ff & !doStrobe;
    wire logic nxt_pd     = doStrobe ? 1'b0 : (powerDown_ff | (enterPowerDown & !inReset_ff)); // R13
    wire logic strobePinLow = !pinSync_ff[hw_reset_pkg::PIN_FETCH] | pinSync_ff[hw_reset_pkg::PIN_ALE];

    generate
        for (gi = 0; gi < hw_reset_pkg::NUM_PORTS; gi++)
        begin : g_port
            wire logic       wrThis = wrHit & (portWrite.port == 3'(gi));
            wire logic [7:0] cur    = latch_ff[gi*8 +: 8];
            assign nxt_latch[gi*8 +: 8] = doStrobe ? hw_reset_pkg::PORT_RESET : // R8
                                          wrThis   ? portWrite.data : cur;
        end
    endgenerate

    // port 0 is open drain: a one in the latch leaves the line floating
    assign nxt_drive.p0PullLow = ~nxt_latch.p0; // R9
    assign nxt_drive.p1Level   = nxt_latch.p1;  // R9
    assign nxt_drive.p2Level   = nxt_latch.p2;  // R9
    assign nxt_drive.p3Level   = nxt_latch.p3;  // R9
    assign nxt_drive.p4Level   = nxt_latch.p4;  // R9

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            armed_ff          <= 1'b0;
            inReset_ff        <= 1'b1;
            oe_ff             <= 1'b0;
            releasePending_ff <= 1'b0;
            strobe_ff         <= 1'b1;
            fetchStart_ff     <= 1'b0;
            fetchAddr_ff      <= hw_reset_pkg::RESET_PC;
            powerDown_ff      <= 1'b0;
            hazard_ff         <= 1'b0;
            latch_ff          <= {hw_reset_pkg::NUM_PORTS{hw_reset_pkg::PORT_RESET}};
            drive_ff          <= '{8'h00, 8'hff, 8'hff, 8'hff, 8'hff};
        end
        else
        begin
            armed_ff          <= nxt_armed;
            inReset_ff        <= nxt_inRst;     // R16
            oe_ff             <= !nxt_inRst;    // R4
            releasePending_ff <= nxt_relPnd;
            strobe_ff         <= doStrobe;      // R10
            fetchStart_ff     <= doRelease;     // R7
            fetchAddr_ff      <= nxt_inRst ? hw_reset_pkg::RESET_PC : fetchAddr_ff; // R7
            powerDown_ff      <= nxt_pd;
            hazard_ff         <= inReset_ff & strobePinLow; // R5
            latch_ff          <= nxt_latch;
            drive_ff          <= nxt_drive;
        end
    end

    // strobes released from input mode only once execution begins
    // own flop, so the direction turns on the same edge as sysReset
    assign aleOe                 = oe_ff; // R4
    assign programFetchStrobeOe  = oe_ff; // R4
    assign aleOut                = hw_reset_pkg::ALE_IDLE;
    assign programFetchStrobeOut = hw_reset_pkg::FETCH_IDLE;
    assign sysReset              = inReset_ff;
    assign sfrLoadDefaults       = strobe_ff;
    assign fetchStart            = fetchStart_ff;
    assign fetchAddr             = fetchAddr_ff;
    // memories have no reset path; writes are only blocked meanwhile
    assign ramWriteBlock         = inReset_ff; // R11
    assign powerDown             = powerDown_ff;
    assign testModeHazard        = hazard_ff;
    assign portLatch             = latch_ff;
    assign portDrive             = drive_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_two_samples_reset: assert property (tick && reqNow && armed_ff |=> sfrLoadDefaults) // R3
        else $error("no reset strobe after second high sample");
    a_single_sample_ok: assert property (tick && reqNow && !armed_ff && !inReset_ff |=> !sfrLoadDefaults) // R3
        else $error("reset strobe after a single sample");
    // the edge after rst still shows the strobe that rst forced
    a_strobe_on_tick: assert property (sfrLoadDefaults && !$past(rst) |-> $past(tick)) // R14
        else $error("reset strobe off the state 5 boundary");
    a_tick_state: assert property (tick |-> stateNum == hw_reset_pkg::STATE_S5) // R14
        else $error("sample point not in state 5");
    a_ports_all_ones: assert property (sfrLoadDefaults |-> portLatch == {5{8'hff}}) // R8
        else $error("port latches not all ones after reset");
    a_port_drive_levels: assert property (sfrLoadDefaults |=> portDrive.p0PullLow == 8'h00
                                          && portDrive.p1Level == 8'hff && portDrive.p4Level == 8'hff) // R9
        else $error("port drive wrong after reset");
    a_strobes_input: assert property (sysReset |-> !aleOe && !programFetchStrobeOe) // R4
        else $error("strobe pin driven during reset");
    a_release_timing: assert property (tick && !reqNow && inReset_ff && !releasePending_ff
                                       ##6 tick && !reqNow |=> fetchStart && !sysReset) // R15
        else $error("execution did not start one cycle after release");
    a_start_address: assert property (fetchStart |-> fetchAddr == 16'h0000) // R7
        else $error("fetch start address not zero");
    a_pd_cleared: assert property (sfrLoadDefaults |-> !powerDown) // R13
        else $error("power-down survived reset");
    a_wdt_resets: assert property (tick && wdtResetReq ##6 tick && wdtResetReq |=> sfrLoadDefaults) // R12
        else $error("watchdog request did not reset");
    a_sync_delay: assert property (resetPin ##1 resetPin |=> pinSync_ff[0]) // R1
        else $error("reset pin not synchronised in two clocks");
    a_ale_sync: assert property (!aleIn ##1 !aleIn
                                 |=> !pinSync_ff[hw_reset_pkg::PIN_ALE]) // R4
        else $error("strobe pin level not synchronised in two clocks");
    a_osc_wdt_resets: assert property (tick && oscWdtResetReq ##6 tick && oscWdtResetReq
                                       |=> sfrLoadDefaults) // R12
        else $error("oscillator watchdog request did not reset");
    a_fetch_single: assert property (fetchStart |=> !fetchStart) // R15
        else $error("execution start longer than one cycle");
    a_oe_after_release: assert property (fetchStart |-> aleOe && programFetchStrobeOe) // R4
        else $error("strobe pins still inputs when execution starts");
    a_latch_hold_reset: assert property (inReset_ff && !doStrobe |=> $stable(portLatch)) // R8
        else $error("port latch changed inside reset");
    a_pd_off_in_reset: assert property (sysReset |-> !powerDown) // R13
        else $error("power-down set while in reset");
    a_addr_in_reset: assert property (sysReset |-> fetchAddr == hw_reset_pkg::RESET_PC) // R7
        else $error("start address not zero during reset");

    c_pin_reset:   cover property (sampleHigh ##6 sampleHigh ##1 sfrLoadDefaults);
    c_release:     cover property (fetchStart);
    c_pd_exit:     cover property (powerDown ##[1:100] sfrLoadDefaults);
    c_short_pulse: cover property (tick && reqNow && !inReset_ff ##6 tick && !reqNow);
    c_osc_wdt:     cover property (tick && oscWdtResetReq ##6 tick && oscWdtResetReq);

endmodule : external_hardware_reset

`default_nettype wire

// ==== tb/board_reset_source.sv ====
`timescale 1ns/1ps
`default_nettype none

module board_reset_source
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output var  logic       resetPin
);
    // power-up: pin high through oscillator start plus two cycles
    logic [7:0] holdCnt_ff = 8'h28;

    always @(negedge clk)
    begin
        if (go)
            holdCnt_ff <= len;
        else if (holdCnt_ff != 8'h00)
            holdCnt_ff <= holdCnt_ff - 8'h01;
    end

    // pin has a pulldown, so released means low; strobe pins are never driven here
    assign resetPin = (holdCnt_ff != 8'h00);
endmodule : board_reset_source

`default_nettype wire

// ==== tb/tb_external_hardware_reset.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_external_hardware_reset;
    logic                      clk = 1'b0;
    logic                      rst = 1'b1;
    logic                      go = 1'b0;
    logic [7:0]                len = 8'h00;
    logic                      resetPin;
    logic                      wdt = 1'b0;
    logic                      oscWdt = 1'b0;
    logic                      enterPowerDown = 1'b0;
    hw_reset_pkg::port_write_t portWrite = '0;
    logic                      aleOut, aleOe, fetchOut, fetchOe;
    logic                      sysReset, sfrLoadDefaults, fetchStart;
    logic [15:0]               fetchAddr;
    logic                      ramWriteBlock, powerDown, testModeHazard;
    hw_reset_pkg::port_latch_t portLatch;
    hw_reset_pkg::port_drive_t portDrive;
    int                        errors = 0;
    int                        compares = 0;
    // released strobe pins rest at idle, nothing outside drives them
    wire aleIn = aleOe ? aleOut : hw_reset_pkg::ALE_IDLE;
    wire fetchIn = fetchOe ? fetchOut : hw_reset_pkg::FETCH_IDLE;

    always #5 clk = ~clk;

    board_reset_source u_src (.clk(clk), .go(go), .len(len), .resetPin(resetPin));

    external_hardware_reset u_dut
    (
        .clk(clk), .rst(rst), .resetPin(resetPin), .wdtResetReq(wdt),
        .oscWdtResetReq(oscWdt), .enterPowerDown(enterPowerDown), .portWrite(portWrite),
        .aleIn(aleIn), .programFetchStrobeIn(fetchIn), .aleOut(aleOut), .aleOe(aleOe),
        .programFetchStrobeOut(fetchOut), .programFetchStrobeOe(fetchOe),
        .sysReset(sysReset), .sfrLoadDefaults(sfrLoadDefaults), .fetchStart(fetchStart),
        .fetchAddr(fetchAddr), .ramWriteBlock(ramWriteBlock), .powerDown(powerDown),
        .testModeHazard(testModeHazard), .portLatch(portLatch), .portDrive(portDrive)
    );

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic pulse_pin(input logic [7:0] n);
        @(negedge clk);
        len <= n;
        go  <= 1'b1;
        @(negedge clk);
        go  <= 1'b0;
    endtask : pulse_pin

    task automatic wait_reset();
        for (int i = 0; i < 40 && sysReset !== 1'b1; i++) @(negedge clk);
        chk("sysReset", 40'h1, sysReset);
        chk("aleOe", 40'h0, aleOe);
        chk("fetchOe", 40'h0, fetchOe);
        chk("ramWriteBlock", 40'h1, ramWriteBlock);
    endtask : wait_reset

    task automatic wait_fetch();
        for (int i = 0; i < 80 && fetchStart !== 1'b1; i++) @(negedge clk);
        chk("fetchStart", 40'h1, fetchStart);
        chk("fetchAddr", 40'h0, fetchAddr);
        chk("aleOe", 40'h1, aleOe);
        chk("fetchOe", 40'h1, fetchOe);
        chk("aleOut", hw_reset_pkg::ALE_IDLE, aleOut);
        chk("fetchOut", hw_reset_pkg::FETCH_IDLE, fetchOut);
        chk("ramWriteBlock", 40'h0, ramWriteBlock);
        chk("sysReset", 40'h0, sysReset);
        @(negedge clk) chk("fetchStart", 40'h0, fetchStart);
    endtask : wait_fetch

    task automatic test_powerup();
        wait_reset();
        chk("portLatch", {5{hw_reset_pkg::PORT_RESET}}, portLatch);
        chk("p0PullLow", 40'h0, portDrive.p0PullLow);
        chk("p1p4", 40'hffffffff, {portDrive.p1Level, portDrive.p2Level,
            portDrive.p3Level, portDrive.p4Level});
        wait_fetch();
    endtask : test_powerup

    task automatic test_short();
        logic seen;
        seen = 1'b0;
        @(negedge clk) portWrite = '{1'b1, 3'h1, 8'h5a};
        @(negedge clk) portWrite = '0;
        @(negedge clk) chk("p1", 40'h5a, portLatch.p1);
        pulse_pin(8'h04);
        repeat (30) @(negedge clk) seen |= sysReset;
        chk("shortPulse", 40'h0, seen);
    endtask : test_short

    task automatic test_hold();
        pulse_pin(8'h14);
        for (int i = 0; i < 40 && sfrLoadDefaults !== 1'b1; i++) @(negedge clk);
        chk("sfrLoad", 40'h1, sfrLoadDefaults);
        wait_reset();
        portWrite = '{1'b1, 3'h2, 8'h00};
        repeat (3) @(negedge clk) chk("sfrLoadGap", 40'h0, sfrLoadDefaults);
        portWrite = '0;
        repeat (3) @(negedge clk);
        chk("sfrLoadRepeat", 40'h1, sfrLoadDefaults);
        chk("p1", 40'hff, portLatch.p1);
        chk("p2", 40'hff, portLatch.p2);
        wait_fetch();
        chk("hazard", 40'h0, testModeHazard);
    endtask : test_hold

    task automatic test_watchdogs();
        for (int k = 0; k < 2; k++)
        begin
            @(negedge clk) {oscWdt, wdt} = (k == 0) ? 2'b01 : 2'b10;
            repeat (14) @(negedge clk);
            wait_reset();
            {oscWdt, wdt} = 2'b00;
            wait_fetch();
        end
    endtask : test_watchdogs

    task automatic test_powerdown();
        @(negedge clk) enterPowerDown = 1'b1;
        @(negedge clk) enterPowerDown = 1'b0;
        @(negedge clk) chk("powerDown", 40'h1, powerDown);
        pulse_pin(8'h0e);
        wait_reset();
        chk("powerDown", 40'h0, powerDown);
        wait_fetch();
    endtask : test_powerdown

    task automatic test_done();
        if (errors == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    initial
    begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        test_powerup();
        test_short();
        test_hold();
        test_watchdogs();
        test_powerdown();
        test_done();
    end

    initial
    begin
        #20000;
        errors++;
        test_done();
    end
endmodule : tb_external_hardware_reset

`default_nettype wire
